// *** src/rbmc_map.svh ***
// Offsets, field positions, reset values and the vector byte count of the bus mode loader.
//==========================================================================
// Behaviour
// RQ1: Straps 000 fetch the vector over an 8-bit multiplexed bus.
// RQ2: Straps 001 fetch the vector over a 16-bit multiplexed bus.
// RQ3: Straps 010 fetch the vector over an 8-bit separate bus.
// RQ4: Straps 011 fetch the vector over a 16-bit separate bus.
// RQ5: The board never straps the top mode pin high.
// RQ6: The reset sequence loads the mode byte from the top vector address.
// RQ7: Only the reset sequence may change the mode register.
// RQ8: Mode register settings apply only after the reset sequence ends.
// RQ9: The stored mode byte keeps every reserved bit at zero. The core stores the byte as read and sets modeError instead.
// RQ10: Access bits 00,01,10,11 select 8/16-bit multiplexed, 8/16-bit separate.
// RQ11: Only bus kind 10 is legal; other codes are forbidden.
// RQ12: With upper address disabled, addressing stays within 64KB.
// RQ13: Low data pins are data lines separate, address/data multiplexed.
// RQ14: Upper data pins: port, data, address or address/data by mode.
// RQ15: Middle address pins carry A15..8 separate, port when multiplexed.
// RQ16: Top address pins carry A23..16 when enabled, else port.
// RQ17: High write strobe only in 16-bit modes; latch and read always.
// RQ18: Function select returns strobes, hold, ready and clock pins to port.
// RQ19: The mode byte should agree with the strapped mode pins.
// RQ20: After reset the four vector and mode bytes are read by hardware.
// RQ21: The mode register is undefined until the sequence loads it.
// RQ22: Straps are sampled at reset release and held through the fetch.
// RQ23: Pin roles follow the straps before, the mode register after.
`ifndef RBMC_MAP_SVH
`define RBMC_MAP_SVH

//==========================================================================
// Vector area
`define RBMC_VEC_BASE      24'hffffdc
`define RBMC_MODE_ADDR     24'hffffdf
`define RBMC_VEC_BYTES     3'h4

//==========================================================================
// Mode byte fields
`define RBMC_BUS_HI        7
`define RBMC_BUS_LO        6
`define RBMC_ACC_HI        5
`define RBMC_ACC_LO        4
`define RBMC_RSVD_MASK     8'h0f
`define RBMC_BUS_LEGAL     2'h2
`define RBMC_MODE_RESET    8'h00

`endif

// *** src/rbmc_pkg.sv ***
// Types shared by the bus mode loader.
package rbmc_pkg;

    typedef enum logic [2:0] {
        RBMC_IDLE  = 3'b000,
        RBMC_FETCH = 3'b001,
        RBMC_WAIT  = 3'b010,
        RBMC_DONE  = 3'b011
    } rbmc_state_t;

    typedef enum logic [1:0] {
        RBMC_MUX8   = 2'b00,
        RBMC_MUX16  = 2'b01,
        RBMC_SEP8   = 2'b10,
        RBMC_SEP16  = 2'b11
    } rbmc_access_t;

endpackage

// *** src/rbmc_pin_roles.sv ***
// Pin role decoder for one access mode.
`timescale 1ns/1ps
module rbmc_pin_roles
    import rbmc_pkg::*;
(
    input  wire rbmc_pkg::rbmc_access_t access,
    input  wire logic                   addrUpperEn,
    input  wire logic                   funcPort,
    output logic                        lowDataMux,
    output logic [1:0]                  upperDataRole,
    output logic                        midAddrBus,
    output logic                        lowAddrBus,
    output logic                        topAddrBus,
    output logic                        writeHighBus,
    output logic                        ctrlPinsBus,
    output logic                        addr64k
);

    always_comb begin
        lowDataMux    = !access[1]; // RQ13
        upperDataRole = {!access[1], access[0]}; // RQ14
        midAddrBus    = access[1]; // RQ15
        lowAddrBus    = access[1]; // RQ15
        topAddrBus    = addrUpperEn && !funcPort; // RQ16 RQ18
        writeHighBus  = access[0] && !funcPort; // RQ17 RQ18
        ctrlPinsBus   = !funcPort; // RQ18
        addr64k       = !topAddrBus; // RQ12
    end

endmodule

// *** src/rbmc_core.sv ***
// Reset-time bus mode loader: strap capture, vector fetch, mode register.
`timescale 1ns/1ps
`include "rbmc_map.svh"
module rbmc_core
    import rbmc_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire logic                   strap_sel_hi,
    input  wire logic                   strap_sel_mid,
    input  wire logic                   strap_sel_lo,
    input  wire logic                   addrUpperEn,
    input  wire logic                   funcPort,
    input  wire logic [7:0]             memData,
    input  wire logic                   memAck,
    output logic                        memReq,
    output logic [23:0]                 memAddr,
    output logic                        fetchWide,
    output logic                        fetchMux,
    output logic [31:0]                 resetVector,
    output logic [7:0]                  modeReg,
    output logic                        seqDone,
    output logic                        strapError,
    output logic                        modeError,
    output rbmc_pkg::rbmc_access_t      activeAccess,
    output logic                        lowDataMux,
    output logic [1:0]                  upperDataRole,
    output logic                        midAddrBus,
    output logic                        lowAddrBus,
    output logic                        topAddrBus,
    output logic                        writeHighBus,
    output logic                        ctrlPinsBus,
    output logic                        addr64k
);

    //======================================================================
    // Strap synchronisers
    // Straps are pins, so they pass three flops before being trusted.
    logic [2:0] strapS1;
    logic [2:0] strapS2;
    logic [2:0] strapS3;
    always_ff @(posedge sys_clk) begin
        strapS1 <= {strap_sel_hi, strap_sel_mid, strap_sel_lo};
        strapS2 <= strapS1;
        strapS3 <= strapS2;
    end

    //======================================================================
    // Sequence state
    rbmc_state_t  state;
    rbmc_state_t  next_state;
    logic [2:0]   strapHeld;
    logic [2:0]   next_strapHeld;
    logic [2:0]   byteIdx;
    logic [2:0]   next_byteIdx;
    logic [7:0]   next_modeReg;
    logic [31:0]  next_resetVector;
    logic         next_memReq;
    logic [23:0]  next_memAddr;
    logic         next_seqDone;
    logic         next_strapError;
    logic         next_modeError;
    rbmc_access_t next_activeAccess;

    always_comb begin
        next_state        = state;
        next_strapHeld    = strapHeld;
        next_byteIdx      = byteIdx;
        next_modeReg      = modeReg;
        next_resetVector  = resetVector;
        next_memReq       = 1'b0;
        next_memAddr      = memAddr;
        next_seqDone      = seqDone;
        next_strapError   = strapError;
        next_modeError    = modeError;
        next_activeAccess = activeAccess;
        case (state)
            RBMC_IDLE: begin
                // Straps are taken once the synchroniser has settled.
                if (strapS2 == strapS3) begin
                    next_strapHeld    = strapS3; // RQ22
                    next_strapError   = strapS3[2]; // RQ5
                    next_activeAccess = rbmc_access_t'({strapS3[1], strapS3[0]}); // RQ1 RQ2 RQ3 RQ4 RQ23
                    next_byteIdx      = 3'h0;
                    next_state        = RBMC_FETCH;
                end
            end
            RBMC_FETCH: begin
                next_memReq  = 1'b1; // RQ20
                next_memAddr = `RBMC_VEC_BASE + {21'h0, byteIdx}; // RQ20
                next_state   = RBMC_WAIT;
            end
            RBMC_WAIT: begin
                next_memReq = 1'b1;
                if (memAck) begin
                    next_memReq = 1'b0;
                    next_resetVector[byteIdx[1:0]*8 +: 8] = memData; // RQ20
                    if (byteIdx == `RBMC_VEC_BYTES - 3'h1) begin
                        // Mode byte lands only here, so software can never write it.
                        next_modeReg   = memData; // RQ6 RQ7
                        next_modeError =
                            (memData[`RBMC_BUS_HI:`RBMC_BUS_LO]
                             != `RBMC_BUS_LEGAL) ||
                            ((memData & `RBMC_RSVD_MASK) != 8'h00); // RQ9 RQ11
                        next_activeAccess = rbmc_access_t'(
                            memData[`RBMC_ACC_HI:`RBMC_ACC_LO]); // RQ8 RQ10 RQ23
                        next_seqDone   = 1'b1; // RQ8
                        next_state     = RBMC_DONE;
                    end else begin
                        next_byteIdx = byteIdx + 3'h1;
                        next_state   = RBMC_FETCH;
                    end
                end
            end
            RBMC_DONE: begin
                next_state = RBMC_DONE; // RQ7
            end
            default: next_state = RBMC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state        <= RBMC_IDLE;
            strapHeld    <= 3'h0;
            byteIdx      <= 3'h0;
            // Undefined after reset in real silicon; zero here for clean sim.
            modeReg      <= `RBMC_MODE_RESET; // RQ21
            resetVector  <= 32'h0;
            memReq       <= 1'b0;
            memAddr      <= 24'h0;
            seqDone      <= 1'b0;
            strapError   <= 1'b0;
            modeError    <= 1'b0;
            activeAccess <= RBMC_MUX8;
        end else begin
            state        <= next_state;
            strapHeld    <= next_strapHeld;
            byteIdx      <= next_byteIdx;
            modeReg      <= next_modeReg;
            resetVector  <= next_resetVector;
            memReq       <= next_memReq;
            memAddr      <= next_memAddr;
            seqDone      <= next_seqDone;
            strapError   <= next_strapError;
            modeError    <= next_modeError;
            activeAccess <= next_activeAccess;
        end
    end

    //======================================================================
    // Vector fetch bus shape, from the held straps only
    logic next_fetchWide;
    logic next_fetchMux;
    always_comb begin
        next_fetchWide = strapHeld[0]; // RQ2 RQ4
        next_fetchMux  = !strapHeld[1]; // RQ1 RQ3
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fetchWide <= 1'b0;
            fetchMux  <= 1'b1;
        end else begin
            fetchWide <= next_fetchWide;
            fetchMux  <= next_fetchMux;
        end
    end

    //======================================================================
    // Pin roles, registered so every output leaves a flop
    logic       rLowDataMux;
    logic [1:0] rUpperDataRole;
    logic       rMidAddrBus;
    logic       rLowAddrBus;
    logic       rTopAddrBus;
    logic       rWriteHighBus;
    logic       rCtrlPinsBus;
    logic       rAddr64k;

    rbmc_pin_roles u_roles (
        .access        (activeAccess),
        .addrUpperEn   (addrUpperEn),
        .funcPort      (funcPort),
        .lowDataMux    (rLowDataMux),
        .upperDataRole (rUpperDataRole),
        .midAddrBus    (rMidAddrBus),
        .lowAddrBus    (rLowAddrBus),
        .topAddrBus    (rTopAddrBus),
        .writeHighBus  (rWriteHighBus),
        .ctrlPinsBus   (rCtrlPinsBus),
        .addr64k       (rAddr64k)
    );

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lowDataMux    <= 1'b1;
            upperDataRole <= 2'h2;
            midAddrBus    <= 1'b0;
            lowAddrBus    <= 1'b0;
            topAddrBus    <= 1'b0;
            writeHighBus  <= 1'b0;
            ctrlPinsBus   <= 1'b1;
            addr64k       <= 1'b1;
        end else begin
            lowDataMux    <= rLowDataMux; // RQ13
            upperDataRole <= rUpperDataRole; // RQ14
            midAddrBus    <= rMidAddrBus; // RQ15
            lowAddrBus    <= rLowAddrBus; // RQ15
            topAddrBus    <= rTopAddrBus; // RQ16
            writeHighBus  <= rWriteHighBus; // RQ17
            ctrlPinsBus   <= rCtrlPinsBus; // RQ18
            addr64k       <= rAddr64k; // RQ12
        end
    end

endmodule

// *** sim/rbmc_core_monitor.sv ***
// Concurrent checks on the bus mode loader ports.
`timescale 1ns/1ps
module rbmc_core_monitor
    import rbmc_pkg::*;
(
    input wire logic [7:0]  memData,
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        addrUpperEn,
    input wire logic        funcPort,
    input wire logic        memAck,
    input wire logic        memReq,
    input wire logic [23:0] memAddr,
    input wire logic        fetchWide,
    input wire logic        fetchMux,
    input wire logic [7:0]  modeReg,
    input wire logic        seqDone,
    input wire rbmc_pkg::rbmc_access_t activeAccess,
    input wire logic        lowDataMux,
    input wire logic [1:0]  upperDataRole,
    input wire logic        midAddrBus,
    input wire logic        topAddrBus,
    input wire logic        writeHighBus,
    input wire logic        ctrlPinsBus,
    input wire logic        addr64k
);
    import rbmc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    //======================================================================
    // Fetch
    property p_addr; memReq |-> memAddr[23:2] == 22'h3ffff7; endproperty
    property p_hold; memReq && !memAck |=> memReq && $stable(memAddr);
    endproperty
    property p_strap; memReq && memAddr != 24'hffffdc
        |-> $stable({fetchWide, fetchMux}); endproperty
    property p_fetch; memReq && !seqDone
        |-> activeAccess == {!fetchMux, fetchWide}; endproperty
    property p_load; memReq && memAck && memAddr[1:0] == 2'h3
        |=> seqDone && modeReg == $past(memData); endproperty
    property p_lock; seqDone |=> seqDone && $stable(modeReg); endproperty
    property p_mode; seqDone |-> activeAccess == modeReg[5:4]; endproperty
    // Pin roles are registered, so they follow their causes one cycle late.
    property p_data; !$past(srst) |-> lowDataMux == !$past(activeAccess[1])
        && midAddrBus == $past(activeAccess[1]) && upperDataRole ==
        {!$past(activeAccess[1]), $past(activeAccess[0])}; endproperty
    property p_ctrl; !$past(srst) |-> ctrlPinsBus == !$past(funcPort)
        && writeHighBus == ($past(activeAccess[0]) && !$past(funcPort))
        && topAddrBus == ($past(addrUpperEn) && !$past(funcPort))
        && addr64k == !topAddrBus; endproperty
    a_addr:
    assert property (p_addr) else $error("fetch outside vector area");
    a_hold:
    assert property (p_hold) else $error("request dropped early");
    a_strap:
    assert property (p_strap) else $error("fetch width moved");
    a_fetch:
    assert property (p_fetch) else $error("fetch access wrong");
    a_load:
    assert property (p_load) else $error("mode byte not loaded");
    a_lock:
    assert property (p_lock) else $error("mode register changed");
    a_mode:
    assert property (p_mode) else $error("access not from mode");
    a_data:
    assert property (p_data) else $error("data pin role wrong");
    a_ctrl:
    assert property (p_ctrl) else $error("control pin role wrong");
    c_done: cover property ($rose(seqDone));
    c_spur: cover property (seqDone && memAck);
    c_func: cover property (seqDone && funcPort && addrUpperEn);
endmodule

// *** sim/rbmc_mem_model.sv ***
// Behavioural external memory answering the vector fetch.
`timescale 1ns/1ps
module rbmc_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        memReq,
    input  wire logic [23:0] memAddr,
    input  wire logic [31:0] image,
    input  wire logic [1:0]  delay,
    input  wire logic        spur,
    output logic [7:0]       memData,
    output logic             memAck
);
    logic [1:0] cnt;
    initial memData = 8'h5a;
    // Data toggles between answers, so a stale byte never looks valid.
    always @(posedge sys_clk) begin
        memAck <= spur;
        memData <= ~memData;
        if (srst || !memReq || memAck) begin
            cnt <= 2'h0;
        end else if (cnt == delay) begin
            memAck <= 1'b1;
            memData <= image[8*memAddr[1:0] +: 8];
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the bus mode loader.
`timescale 1ns/1ps
module tb;
    import rbmc_pkg::*;
    logic         sys_clk, srst, addrUpperEn, funcPort, spur, memAck;
    logic         memReq, fetchWide, fetchMux, seqDone, strapError;
    logic         modeError, lowDataMux, midAddrBus, lowAddrBus;
    logic         topAddrBus, writeHighBus, ctrlPinsBus, addr64k;
    logic [1:0]   upperDataRole, delay;
    logic [2:0]   straps;
    logic [7:0]   memData, modeReg;
    logic [23:0]  memAddr;
    logic [31:0]  resetVector, image;
    rbmc_access_t activeAccess;
    int           errorCnt = 0;
    int           nCompared = 0;
    rbmc_core rbmc_core_inst (.sys_clk, .srst, .strap_sel_hi(straps[2]),
        .strap_sel_mid(straps[1]), .strap_sel_lo(straps[0]), .addrUpperEn,
        .funcPort, .memData, .memAck, .memReq, .memAddr, .fetchWide,
        .fetchMux, .resetVector, .modeReg, .seqDone, .strapError,
        .modeError, .activeAccess, .lowDataMux, .upperDataRole,
        .midAddrBus, .lowAddrBus, .topAddrBus, .writeHighBus,
        .ctrlPinsBus, .addr64k);
    rbmc_mem_model rbmc_mem_model_inst (.sys_clk, .srst, .memReq,
        .memAddr, .image, .delay, .spur, .memData, .memAck);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // The stored mode byte matches the straps unless a test says otherwise.
    task automatic boot(input logic [2:0] s, input logic [7:0] mode);
        @(posedge sys_clk);
        straps <= s;
        image <= {mode, 24'hc3a581};
        srst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            for (int n = 0; n < 20 && memReq !== 1'b1; n++) @(negedge sys_clk);
            check("memAddr", 24'hffffdc + k, memAddr);
            check("fetchWide", s[0], fetchWide);
            check("fetchMux", !s[1], fetchMux);
            check("fetchAccess", s[1:0], activeAccess);
            for (int n = 0; n < 20 && memReq === 1'b1; n++) @(negedge sys_clk);
        end
        repeat (2) @(negedge sys_clk);
        check("resetVector", {mode, 24'hc3a581}, resetVector);
        check("modeReg", mode, modeReg);
        check("strapError", s[2], strapError);
    endtask
    task automatic test_straps();
        logic [1:0] a;
        // Expected upper data role for mux8, mux16, sep8 and sep16.
        logic [1:0] role [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
        for (int i = 0; i < 4; i++) begin
            a = i[1:0];
            boot({1'b0, a}, {2'h2, a, 4'h0});
            check("lowDataMux", !a[1], lowDataMux);
            check("upperDataRole", role[i], upperDataRole);
            check("lowAddrBus", a[1], lowAddrBus);
            check("writeHighBus", a[0], writeHighBus);
            check("modeError", 1'b0, modeError);
        end
        $display("test_straps done");
    endtask
    task automatic test_pins();
        boot(3'h3, 8'hb0);
        for (int j = 0; j < 4; j++) begin
            @(posedge sys_clk);
            {addrUpperEn, funcPort} <= j[1:0];
            repeat (2) @(negedge sys_clk);
            check("topAddrBus", j == 2, topAddrBus);
            check("addr64k", j != 2, addr64k);
            check("ctrlPinsBus", !j[0], ctrlPinsBus);
            check("writeHighBus", !j[0], writeHighBus);
        end
        $display("test_pins done");
    endtask
    task automatic test_order();
        boot(3'h3, 8'h50);
        check("activeAccess", 2'h1, activeAccess);
        check("modeError", 1'b1, modeError);
        check("upperDataRole", 2'h3, upperDataRole);
        // A reserved bit set in an otherwise legal mode byte is flagged.
        boot(3'h0, 8'h81);
        check("modeError", 1'b1, modeError);
        // Forbidden straps are flagged but the fetch still runs.
        boot(3'h4, 8'h80);
        check("modeError", 1'b0, modeError);
        check("activeAccess", 2'h0, activeAccess);
        $display("test_order done");
    endtask
    task automatic test_lock();
        @(posedge sys_clk);
        delay <= 2'h3;
        boot(3'h2, 8'ha0);
        @(posedge sys_clk);
        image <= 32'h50ffffff;
        spur <= 1'b1;
        repeat (3) @(posedge sys_clk);
        spur <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check("modeReg", 8'ha0, modeReg);
        check("resetVector", 32'ha0c3a581, resetVector);
        check("activeAccess", 2'h2, activeAccess);
        $display("test_lock done");
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        errorCnt++;
        report_and_stop();
    end
    initial begin
        {srst, straps, addrUpperEn, funcPort, spur} = 7'h40;
        delay = 2'h0;
        image = 32'h0;
        test_straps();
        test_pins();
        test_order();
        test_lock();
        report_and_stop();
    end
endmodule
bind rbmc_core rbmc_core_monitor rbmc_core_monitor_inst (.memData,
    .sys_clk, .srst, .addrUpperEn, .funcPort, .memAck, .memReq, .memAddr,
    .fetchWide, .fetchMux, .modeReg, .seqDone, .activeAccess, .lowDataMux,
    .upperDataRole, .midAddrBus, .topAddrBus, .writeHighBus, .ctrlPinsBus,
    .addr64k);
